/* File: core/asp_serial_port.sv */
// Serial control and data port of the converter: config byte in, result out, ready strobe
`timescale 1ns/10ps
`include "asp_params.svh"

module asp_serial_port (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic chipSelectN,
	input wire logic serialClk,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	output logic resultReadyStrobe,
	input wire logic internalClockMode,
	input wire logic resultValid,
	input wire logic [`ASP_RESULT_WIDTH-1:0] resultData,
	output logic [`ASP_CHAN_WIDTH-1:0] channelSelect,
	output logic inputPairingSelect,
	output logic configValid
);
	import asp_pkg::*;

	asp_pin_if pins ();

	asp_state_type state_reg;
	asp_state_type state_next;
	logic [`ASP_CFG_WIDTH-1:0] rxShift_reg;
	logic [`ASP_CFG_WIDTH-1:0] rxShift_next;
	logic [`ASP_CNT_WIDTH-1:0] bitCnt_reg;
	logic [`ASP_CNT_WIDTH-1:0] bitCnt_next;
	logic [`ASP_CHAN_WIDTH-1:0] chan_reg;
	logic [`ASP_CHAN_WIDTH-1:0] chan_next;
	logic pair_reg;
	logic pair_next;
	logic cfgValid_reg;
	logic cfgValid_next;
	logic [`ASP_RESULT_WIDTH-1:0] pending_reg;
	logic [`ASP_RESULT_WIDTH-1:0] pending_next;
	logic [`ASP_RESULT_WIDTH-1:0] txShift_reg;
	logic [`ASP_RESULT_WIDTH-1:0] txShift_next;
	logic serOut_reg;
	logic serOut_next;
	logic serOutEn_reg;
	logic serOutEn_next;
	logic strobe_reg;
	logic strobe_next;

	asp_pin_sync u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.chipSelectN(chipSelectN),
		.serialClk(serialClk),
		.serialIn(serialIn),
		.pins(pins)
	);

	//------------------------------------------------------------
	// Configuration byte receiver
	//------------------------------------------------------------
	// Hunts for the start bit, then collects the remaining seven bits
	always_comb begin
		logic [`ASP_CFG_WIDTH-1:0] byteIn;
		byteIn = {rxShift_reg[`ASP_CFG_WIDTH-2:0], pins.dinLevel};
		state_next = state_reg;
		rxShift_next = rxShift_reg;
		bitCnt_next = bitCnt_reg;
		chan_next = chan_reg;
		pair_next = pair_reg;
		cfgValid_next = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				// Clock and data are ignored while deselected
				rxShift_next = `ASP_RX_CLEAR;
				bitCnt_next = `ASP_CNT_ZERO;
				if (pins.csLow) begin
					state_next = ST_HUNT;
				end
			end
			ST_HUNT: begin
				if (!pins.csLow) begin
					state_next = ST_IDLE;
				end else if (pins.sclkRise && pins.dinLevel) begin
					// First one seen is the start bit, byte MSB
					rxShift_next = `ASP_RX_START;
					bitCnt_next = `ASP_CNT_ONE;
					state_next = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (!pins.csLow) begin
					// Partial byte dropped on deselect
					rxShift_next = `ASP_RX_CLEAR;
					bitCnt_next = `ASP_CNT_ZERO;
					state_next = ST_IDLE;
				end else if (pins.sclkRise) begin
					rxShift_next = byteIn;
					if (bitCnt_reg + `ASP_CNT_ONE == `ASP_CNT_FULL) begin
						chan_next = byteIn[`ASP_CHAN_HI:`ASP_CHAN_LO];
						pair_next = byteIn[`ASP_PAIR_POS];
						cfgValid_next = 1'b1;
						bitCnt_next = `ASP_CNT_ZERO;
						state_next = ST_HUNT;
					end else begin
						bitCnt_next = bitCnt_reg + `ASP_CNT_ONE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			rxShift_reg <= `ASP_RX_CLEAR;
			bitCnt_reg <= `ASP_CNT_ZERO;
			chan_reg <= '0;
			pair_reg <= 1'b0;
			cfgValid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			rxShift_reg <= rxShift_next;
			bitCnt_reg <= bitCnt_next;
			chan_reg <= chan_next;
			pair_reg <= pair_next;
			cfgValid_reg <= cfgValid_next;
		end
	end

	//------------------------------------------------------------
	// Result shifter and ready strobe
	//------------------------------------------------------------
	// Result is loaded at select fall so a new result cannot tear a read
	always_comb begin
		pending_next = resultValid ? resultData : pending_reg;
		txShift_next = txShift_reg;
		serOut_next = serOut_reg;
		serOutEn_next = serOutEn_reg;
		if (!pins.csLow) begin
			serOutEn_next = 1'b0;
			serOut_next = 1'b0;
		end else if (pins.csFall) begin
			serOutEn_next = 1'b1;
			serOut_next = pending_reg[`ASP_RESULT_MSB];
			txShift_next = {pending_reg[`ASP_RESULT_MSB-1:0], 1'b0};
		end else if (pins.sclkFall) begin
			serOut_next = txShift_reg[`ASP_RESULT_MSB];
			txShift_next = {txShift_reg[`ASP_RESULT_MSB-1:0], 1'b0};
		end
		// Driven in every select state; a new result wins over the read clear
		if (!internalClockMode) begin
			strobe_next = 1'b0;
		end else if (resultValid) begin
			strobe_next = 1'b1;
		end else if (pins.csFall) begin
			strobe_next = 1'b0;
		end else begin
			strobe_next = strobe_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pending_reg <= `ASP_RESULT_CLEAR;
			txShift_reg <= `ASP_RESULT_CLEAR;
			serOut_reg <= 1'b0;
			serOutEn_reg <= 1'b0;
			strobe_reg <= 1'b0;
		end else begin
			pending_reg <= pending_next;
			txShift_reg <= txShift_next;
			serOut_reg <= serOut_next;
			serOutEn_reg <= serOutEn_next;
			strobe_reg <= strobe_next;
		end
	end

	// Every output straight from a flop
	assign serialOut = serOut_reg;
	assign serialOutEn = serOutEn_reg;
	assign resultReadyStrobe = strobe_reg;
	assign channelSelect = chan_reg;
	assign inputPairingSelect = pair_reg;
	assign configValid = cfgValid_reg;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	a_rx_sample: assert property (
		@(posedge core_clk) disable iff (!rstn)
		(state_reg == ST_SHIFT && pins.csLow && pins.sclkRise)
		|=> rxShift_reg[0] == $past(pins.dinLevel))
		else $error("input bit not shifted on clock rise");

	a_tx_next_bit: assert property (
		@(posedge core_clk) disable iff (!rstn)
		(pins.csLow && !pins.csFall && pins.sclkFall)
		|=> serialOut == $past(txShift_reg[`ASP_RESULT_MSB]))
		else $error("output bit not advanced on clock fall");

	a_out_float: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!pins.csLow |=> !serialOutEn)
		else $error("output driven while deselected");

	a_rx_cleared: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!pins.csLow |=> (bitCnt_reg == `ASP_CNT_ZERO && !configValid))
		else $error("receiver active while deselected");

	a_strobe_rise: assert property (
		@(posedge core_clk) disable iff (!rstn)
		(internalClockMode && resultValid) |=> resultReadyStrobe)
		else $error("strobe did not rise on result");

	a_strobe_ext: assert property (
		@(posedge core_clk) disable iff (!rstn)
		!internalClockMode |=> !resultReadyStrobe)
		else $error("strobe high in external clock mode");

	a_start_hunt: assert property (
		@(posedge core_clk) disable iff (!rstn)
		(state_reg == ST_HUNT && pins.csLow && pins.sclkRise && !pins.dinLevel)
		|=> state_reg == ST_HUNT)
		else $error("zero bit taken as start bit");

	a_cfg_fields: assert property (
		@(posedge core_clk) disable iff (!rstn)
		configValid |-> (channelSelect == $past(rxShift_reg[`ASP_CHAN_HI-1:`ASP_CHAN_LO-1])
			&& inputPairingSelect == $past(rxShift_reg[`ASP_PAIR_POS-1])))
		else $error("channel or pairing field wrong");
endmodule

/* File: core/asp_params.svh */
// Constants for the converter serial port: bit positions, widths and counts
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

`define ASP_CFG_WIDTH 8
`define ASP_CHAN_HI 6
`define ASP_CHAN_LO 4
`define ASP_PAIR_POS 3
`define ASP_CHAN_WIDTH 3
`define ASP_RESULT_WIDTH 16
`define ASP_RESULT_MSB 15
`define ASP_CNT_WIDTH 4
`define ASP_CNT_ZERO 4'h0
`define ASP_CNT_ONE 4'h1
`define ASP_CNT_FULL 4'h8
`define ASP_RX_CLEAR 8'h00
`define ASP_RX_START 8'h01
`define ASP_RESULT_CLEAR 16'h0000
`define ASP_PIN_COUNT 3
`define ASP_PIN_RESET 3'h4
`define ASP_PIN_SEL 2
`define ASP_PIN_CLK 1
`define ASP_PIN_DATA 0

`endif

/* File: core/asp_pkg.sv */
// Types shared by the converter serial port modules
package asp_pkg;

	// Receive state, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HUNT = 3'b010,
		ST_SHIFT = 3'b100
	} asp_state_type;

endpackage

/* File: core/asp_pin_if.sv */
// Synchronised pin levels and edge pulses passed from the sampler to the port core
`timescale 1ns/10ps

interface asp_pin_if;
	logic csLow;
	logic csFall;
	logic sclkRise;
	logic sclkFall;
	logic dinLevel;

	modport drv (
		output csLow,
		output csFall,
		output sclkRise,
		output sclkFall,
		output dinLevel
	);

	modport use_side (
		input csLow,
		input csFall,
		input sclkRise,
		input sclkFall,
		input dinLevel
	);
endinterface

/* File: core/asp_pin_sync.sv */
// Two-flop synchroniser and edge finder for select, serial clock and serial input
`timescale 1ns/10ps
`include "asp_params.svh"

module asp_pin_sync (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic chipSelectN,
	input wire logic serialClk,
	input wire logic serialIn,
	asp_pin_if.drv pins
);
	import asp_pkg::*;

	// Bit order in each stage: {select, clock, data}
	logic [`ASP_PIN_COUNT-1:0] meta_reg;
	logic [`ASP_PIN_COUNT-1:0] meta_next;
	logic [`ASP_PIN_COUNT-1:0] sync_reg;
	logic [`ASP_PIN_COUNT-1:0] sync_next;
	logic [`ASP_PIN_COUNT-1:0] prev_reg;
	logic [`ASP_PIN_COUNT-1:0] prev_next;

	function automatic logic edgeRise(input logic prevLevel, input logic curLevel);
		edgeRise = curLevel & ~prevLevel;
	endfunction

	//------------------------------------------------------------
	// Sampling chain
	//------------------------------------------------------------
	// First stage feeds only the second; edges are taken one stage later
	always_comb begin
		meta_next = {chipSelectN, serialClk, serialIn};
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	// Select resets high so the port starts deselected
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= `ASP_PIN_RESET;
			sync_reg <= `ASP_PIN_RESET;
			prev_reg <= `ASP_PIN_RESET;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// Levels and one-cycle edge pulses; data stays aligned with clock edges
	assign pins.csLow = ~sync_reg[`ASP_PIN_SEL];
	assign pins.csFall = edgeRise(~prev_reg[`ASP_PIN_SEL], ~sync_reg[`ASP_PIN_SEL]);
	assign pins.sclkRise = edgeRise(prev_reg[`ASP_PIN_CLK], sync_reg[`ASP_PIN_CLK]);
	assign pins.sclkFall = edgeRise(~prev_reg[`ASP_PIN_CLK], ~sync_reg[`ASP_PIN_CLK]);
	assign pins.dinLevel = sync_reg[`ASP_PIN_DATA];
endmodule

/* File: tb/asp_host_model.sv */
// Host serial master model driving select, link clock and data
`timescale 1ns/10ps

module asp_host_model (
	output logic chipSelectN,
	output logic serialClk,
	output logic serialIn,
	input wire logic serialOut,
	input wire logic serialOutEn,
	output logic [15:0] readWord,
	output logic frameDone
);
	// Idle pins: select high, link clock parked low
	initial begin
		chipSelectN = 1'b1;
		serialClk = 1'b0;
		serialIn = 1'b0;
		readWord = 16'h0000;
		frameDone = 1'b0;
	end

	// One frame, MSB first, 80 ns link clock; sel low keeps select high
	task automatic frame(input logic [23:0] bits, input int nb, input logic sel);
		chipSelectN = ~sel;
		#48;
		for (int i = 0; i < nb; i++) begin
			serialIn = bits[23 - i];
			#40 serialClk = 1'b1;
			// Floating output reads as unknown, so a missing enable shows
			if (i < 16) readWord[15 - i] = serialOutEn ? serialOut : 1'bx;
			#40 serialClk = 1'b0;
		end
		#40 chipSelectN = 1'b1;
		// Released data line shows the inverse of its last value
		serialIn = ~serialIn;
		#48;
		if (sel) begin
			frameDone = 1'b1;
			#8 frameDone = 1'b0;
		end
	endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the converter serial port
`timescale 1ns/10ps
`include "asp_params.svh"

module tb_top;
	logic core_clk, rstn, chipSelectN, serialClk, serialIn, serialOut, serialOutEn;
	logic resultReadyStrobe, internalClockMode, resultValid, inputPairingSelect;
	logic configValid, frameDone;
	logic [`ASP_RESULT_WIDTH-1:0] resultData, readWord, lfsrReg;
	logic [`ASP_CHAN_WIDTH-1:0] channelSelect;
	logic [3:0] cfgQueue[$];
	logic [15:0] wordQueue[$];
	int err_count, comparisons;

	asp_serial_port asp_serial_port_i (.core_clk(core_clk), .rstn(rstn),
		.chipSelectN(chipSelectN), .serialClk(serialClk), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn),
		.resultReadyStrobe(resultReadyStrobe), .internalClockMode(internalClockMode),
		.resultValid(resultValid), .resultData(resultData), .channelSelect(channelSelect),
		.inputPairingSelect(inputPairingSelect), .configValid(configValid));

	asp_host_model asp_host_model_i (.chipSelectN(chipSelectN), .serialClk(serialClk),
		.serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
		.readWord(readWord), .frameDone(frameDone));

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Config fields: channel and pairing as one nibble
	task automatic check_cfg(input string what, input logic [3:0] exp, input logic [3:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Whole words read back or counted
	task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Single output levels
	task automatic check_level(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic pulse_result(input logic [15:0] d);
		@(posedge core_clk) #1;
		resultValid = 1'b1;
		resultData = d;
		@(posedge core_clk) #1;
		resultValid = 1'b0;
		@(posedge core_clk) #1;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Config monitor: away from the edge so registered outputs are settled
	always @(negedge core_clk) begin
		if (configValid === 1'b1) begin
			if (cfgQueue.size() == 0) check_level("stray config", 1'b0, configValid);
			else check_cfg("config", cfgQueue.pop_front(), {channelSelect, inputPairingSelect});
		end
	end

	// Read monitor: only frames that were promised a result are compared
	always @(posedge frameDone) begin
		if (wordQueue.size() != 0) check_word("read word", wordQueue.pop_front(), readWord);
	end

	// Hang guard well above the longest sequence
	initial begin
		#500000;
		err_count++;
		end_sim();
	end

	initial begin
		rstn = 1'b0;
		internalClockMode = 1'b1;
		resultValid = 1'b0;
		resultData = 16'h0000;
		err_count = 0;
		comparisons = 0;
		lfsrReg = 16'h0015;
		repeat (4) @(posedge core_clk);
		#1 rstn = 1'b1;
		repeat (3) @(posedge core_clk);
		// Pins move 1 ns after an edge; frame lengths keep that phase
		#1;
		// Every channel and pairing, zeros ahead of the start bit
		for (int c = 0; c < 16; c++) begin
			cfgQueue.push_back(c[3:0]);
			asp_host_model_i.frame({3'b000, 1'b1, c[3:0], 3'b101, 13'h0000}, 11, 1'b1);
		end
		$display("channel sweep ended");
		// Results read back, each with a random config in the same frame
		for (int k = 0; k < 4; k++) begin
			lfsrReg = lfsr_next(lfsrReg);
			pulse_result(lfsrReg);
			check_level("strobe set", 1'b1, resultReadyStrobe);
			repeat (10) @(posedge core_clk);
			#1;
			check_level("strobe held", 1'b1, resultReadyStrobe);
			wordQueue.push_back(lfsrReg);
			cfgQueue.push_back(lfsrReg[6:3]);
			asp_host_model_i.frame({1'b1, lfsrReg[6:0], 16'h0000}, 16, 1'b1);
			check_level("disabled", 1'b0, serialOutEn);
			// Read start clears the strobe when no new result arrives
			check_level("strobe cleared", 1'b0, resultReadyStrobe);
		end
		$display("readback ended");
		// Traffic with select high must leave no trace; output must float
		asp_host_model_i.frame(24'hff_ffff, 16, 1'b0);
		check_word("float read", 16'hxxxx, readWord);
		// Partial byte dropped by select rise
		asp_host_model_i.frame({4'b1011, 20'h0_0000}, 4, 1'b1);
		// One leading zero, then a full byte: channel 2, differential
		cfgQueue.push_back(4'b0101);
		asp_host_model_i.frame({9'b0_1010_1000, 15'h0000}, 9, 1'b1);
		$display("select tests ended");
		// External mode: strobe forced low, even with a result waiting
		pulse_result(16'h1234);
		internalClockMode = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		check_level("ext strobe", 1'b0, resultReadyStrobe);
		pulse_result(16'h4321);
		check_level("ext strobe", 1'b0, resultReadyStrobe);
		$display("external mode ended");
		repeat (20) @(posedge core_clk);
		check_word("queues empty", 16'h0000, 16'(cfgQueue.size() + wordQueue.size()));
		end_sim();
	end
endmodule
